/* rtl/rxmsg_irq.sv */
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module rxmsg_irq
    import rxmsg_pkg::*;
#(
    parameter int FRAME_CYCLES = FRAME_CYC,
    parameter int DEPTH_LOG2   = 6
) (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [ADDR_W-1:0] haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic      [31:0]       hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    input  wire logic              rx_word_valid,
    input  wire logic [31:0]       rx_word,
    input  wire logic              rx_msg_done,
    input  wire logic              rx_crc_bad,
    input  wire logic [2:0]        rx_user,
    input  wire logic [1:0]        rx_page,
    input  wire logic [1:0]        rx_link,
    output logic                   irq,
    output logic                   rx_user2_pin,
    output logic                   input_memory_switch,
    output logic                   output_memory_switch
);
    // ========================================================
    // Storage and state.
    localparam int WPM = DEPTH_LOG2 - 3;   // Word bits per message.
    logic [31:0]  mem [1<<DEPTH_LOG2];     // Message words.
    logic [7:0]   slot_crc;                // Per slot CRC error.
    logic [2:0]   wr_slot;                 // Slot being filled.
    logic [WPM-1:0] wr_word;               // Word within it.
    logic [2:0]   rd_slot;                 // Head slot.
    logic [WPM-1:0] rd_word;               // Next word to fetch.
    logic         touched;                 // Head partly read.
    logic [3:0]   rx_message_count;        // Messages held.
    logic [31:0]  rd_data;                 // Prefetched word.
    logic [2:0]   busy_cnt;                // Transfer countdown.
    rxmsg_st_t    st;                      // Transfer engine.
    logic         fifo_transfer_busy;      // Engine active.
    logic         head_crc;                // Head CRC flag.
    logic         slot_crc_error;          // Last slot CRC flag.
    logic         sync_done;               // Resync completed.
    logic [2:0]   user;                    // Clean user bits.
    logic [1:0]   rx_page_bits;            // Clean page bits.
    logic [1:0]   link;                    // Clean link bits.
    logic         status_valid;            // Fields stable.
    logic [15:0]  en_ctrl;                 // Enable register.
    logic [3:0]   fctrl;                   // Control register.
    logic [6:0]   reason;                  // Sticky flags.
    logic         thr_hit_q;               // Threshold seen.
    logic [$clog2(FRAME_CYCLES)-1:0] frame_cnt;
    logic         frame_tick;              // One per frame.
    logic [2:0]   tmo_frames;              // Frames since read.
    // ========================================================
    // Bus address phase capture.
    logic         dph_wr;                  // Write data phase.
    logic [7:0]   dph_idx;                 // Its register index.
    logic         aph;                     // Valid address phase.
    logic [7:0]   aph_idx;                 // Word index of haddr.
    logic         rd_data_req;             // Data word read.
    logic         rd_reason;               // Reason read.
    logic         wr_sync;                 // Resync request.
    logic         commit;                  // Message committed.
    logic         clean;                   // Committed clean.
    logic         full;                    // FIFO holds eight.
    logic         advance;                 // Head slot freed.
    logic [6:0]   sets;                    // Flag set events.
    // Threshold and timeout codes become counts of one up.
    function automatic logic [3:0] code_plus_one(
        input logic [2:0] code);
        code_plus_one = {1'b0, code} + 4'h1;
    endfunction
    // Aligned word index, from a byte address.
    function automatic logic [7:0] word_idx(
        input logic [ADDR_W-1:0] a);
        word_idx = a[ADDR_W-1:2];
    endfunction
    assign aph     = hsel && hready && htrans[1];
    assign aph_idx = word_idx(haddr);
    assign rd_data_req = aph && !hwrite && aph_idx == IDX_DATA
                         && st == RXM_IDLE;
    assign rd_reason   = aph && !hwrite && aph_idx == IDX_REASON;
    assign wr_sync = dph_wr && dph_idx == IDX_STATUS && hwdata[0];
    assign full    = rx_message_count == LVL_MAX;
    assign commit  = rx_msg_done;
    assign clean   = commit && !rx_crc_bad;

    // ========================================================
    // Bus slave: no wait states, always OKAY, read data and
    // read side effects both taken at the address phase edge.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_wr    <= 1'b0;
            dph_idx   <= 8'h00;
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            dph_wr  <= aph && hwrite;
            dph_idx <= aph_idx;
            if (aph && !hwrite) begin
                case (aph_idx)
                    IDX_DATA:   hrdata <= rd_data;
                    IDX_FCTRL:  hrdata <= {28'h0, fctrl};
                    IDX_IRQ_EN: hrdata <= {16'h0, en_ctrl};
                    IDX_REASON: hrdata <= {25'h0, reason};
                    IDX_STATUS: hrdata <= {16'h0, status_valid,
                        link, rx_page_bits, user, head_crc,
                        slot_crc_error, rx_message_count,
                        fifo_transfer_busy, sync_done};
                    default:    hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end
    // Software writable control, masked to the writable bits.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            en_ctrl <= EN_RESET;
            fctrl   <= 4'h0;
        end else if (dph_wr && dph_idx == IDX_IRQ_EN) begin
            en_ctrl <= hwdata[15:0] & EN_RW_MASK;
        end else if (dph_wr && dph_idx == IDX_FCTRL) begin
            fctrl   <= hwdata[3:0];
        end
    end

    // ========================================================
    // Receive side: words of the slot being filled, then a
    // commit marks the slot as a whole message.
    always_ff @(posedge hclk) begin
        if (rx_word_valid && !full)
            mem[{wr_slot, wr_word}] <= rx_word;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_slot  <= 3'h0;
            wr_word  <= '0;
            slot_crc <= 8'h00;
        end else if (commit) begin
            wr_word <= '0;
            if (!full) begin
                slot_crc[wr_slot] <= rx_crc_bad;
                wr_slot <= wr_slot + 3'h1;
            end
        end else if (rx_word_valid && !full && !(&wr_word)) begin
            wr_word <= wr_word + 1'b1;
        end
    end
    // Level only moves by one each way, so it stays in range.
    assign advance = st != RXM_IDLE && busy_cnt == 3'h1 &&
                     (st == RXM_SYNC ? touched : &rd_word) &&
                     rx_message_count != 4'h0;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_message_count <= 4'h0;
        end else if (commit && !full && !advance) begin
            rx_message_count <= rx_message_count + 4'h1;
        end else if (advance && !(commit && !full)) begin
            rx_message_count <= rx_message_count - 4'h1;
        end
    end
    // Slot flag follows every slot; header fields only clean.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            slot_crc_error <= 1'b0;
            user           <= 3'h0;
            rx_page_bits   <= 2'h0;
            link           <= 2'h0;
        end else if (commit) begin
            slot_crc_error <= rx_crc_bad;
            if (!rx_crc_bad) begin
                user         <= rx_user;
                rx_page_bits <= rx_page;
                link         <= rx_link;
            end
        end
    end
    // Fields move on a commit, so they are flagged unstable
    // for that cycle; software simply reads again.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            status_valid <= 1'b0;
        else
            status_valid <= !commit;
    end

    // ========================================================
    // Transfer engine: data reads and resyncs prefetch one word.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st        <= RXM_IDLE;
            busy_cnt  <= 3'h0;
            rd_slot   <= 3'h0;
            rd_word   <= '0;
            touched   <= 1'b0;
            rd_data   <= 32'h0000_0000;
            sync_done <= 1'b0;
        end else begin
            case (st)
                RXM_IDLE: begin
                    if (wr_sync) begin
                        st        <= RXM_SYNC;
                        sync_done <= 1'b0;
                        busy_cnt  <= fctrl[FC_FAST] ?
                            SYNC_CYC_FAST : SYNC_CYC_SLOW;
                    end else if (rd_data_req) begin
                        st       <= RXM_READ;
                        busy_cnt <= fctrl[FC_FAST] ?
                            RD_CYC_FAST : RD_CYC_SLOW;
                    end
                end
                RXM_READ, RXM_SYNC: begin
                    busy_cnt <= busy_cnt - 3'h1;
                    if (busy_cnt == 3'h1) begin
                        st <= RXM_IDLE;
                        if (st == RXM_SYNC) begin
                            sync_done <= 1'b1;
                            if (touched) begin
                                rd_slot <= rd_slot + 3'h1;
                                rd_word <= '0;
                                touched <= 1'b0;
                            end
                            rd_data <= mem[{rd_slot + 3'(touched),
                                            {WPM{1'b0}}}];
                        end else begin
                            rd_word <= rd_word + 1'b1;
                            touched <= !(&rd_word);
                            if (&rd_word)
                                rd_slot <= rd_slot + 3'h1;
                            rd_data <= mem[{rd_slot + 3'(&rd_word),
                                            rd_word + 1'b1}];
                        end
                    end
                end
                default: st <= RXM_IDLE;
            endcase
        end
    end
    // Busy shows the engine. The head flag settles a cycle early on a fast resync
    // and with busy on a slow resync or on a read.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fifo_transfer_busy <= 1'b0;
            head_crc           <= 1'b0;
        end else begin
            fifo_transfer_busy <= st != RXM_IDLE &&
                                  busy_cnt != 3'h1;
            if (st == RXM_SYNC && busy_cnt ==
                (fctrl[FC_FAST] ? 3'h2 : 3'h1))
                head_crc <= slot_crc[rd_slot +
                                     3'(touched)];
            else if (st == RXM_READ && busy_cnt == 3'h1 && &rd_word)
                head_crc <= slot_crc[rd_slot + 3'h1];
        end
    end

    // ========================================================
    // Frame timing and the stale message timeout.
    assign frame_tick = frame_cnt == FRAME_CYCLES - 1;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            frame_cnt <= '0;
        else if (frame_tick)
            frame_cnt <= '0;
        else
            frame_cnt <= frame_cnt + 1'b1;
    end
    // Firing on tick N+1 after a read keeps the delay between
    // N and N+1 frames, whatever the phase of the read.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            tmo_frames <= 3'h0;
        else if (rd_data_req)
            tmo_frames <= 3'h0;
        else if (frame_tick && tmo_frames != 3'h7)
            tmo_frames <= tmo_frames + 3'h1;
    end

    // ========================================================
    // Event flags: a set in the clearing cycle survives.
    always_comb begin
        sets = 7'h00;
        sets[RS_USER0] = clean && rx_user[0] && !user[0];
        sets[RS_PAGE_LSB +: 2] = clean ?
            (rx_page ^ rx_page_bits) : 2'h0;
        sets[RS_LINK] = clean && rx_link != link;
        sets[RS_OVF]  = commit && full;
        sets[RS_THR]  = !thr_hit_q && rx_message_count >=
            code_plus_one(en_ctrl[EN_THR_LSB +: 3]);
        sets[RS_TMO]  = frame_tick && !rd_data_req &&
            rx_message_count != 4'h0 && {1'b0, tmo_frames} ==
            code_plus_one({1'b0, en_ctrl[EN_TMO_LSB +: 2]});
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reason    <= 7'h00;
            thr_hit_q <= 1'b0;
        end else begin
            thr_hit_q <= rx_message_count >=
                code_plus_one(en_ctrl[EN_THR_LSB +: 3]);
            if (rd_reason)
                reason <= sets;
            else
                reason <= reason | sets;
        end
    end
    // Interrupt and pins, all registered.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq                  <= 1'b0;
            rx_user2_pin         <= 1'b0;
            input_memory_switch  <= 1'b0;
            output_memory_switch <= 1'b0;
        end else begin
            irq <= |(reason & en_ctrl[6:0]);
            rx_user2_pin <= fctrl[FC_PROT] & user[2];
            if (fctrl[FC_PROT]) begin
                input_memory_switch  <= rx_page_bits[1];
                output_memory_switch <= rx_page_bits[0];
            end
        end
    end

    // ========================================================
    // Checks.
    sequence s_clean_commit;
        commit && !rx_crc_bad;
    endsequence
    sequence s_reason_read;
        rd_reason ##1 1'b1;
    endsequence
    a_level_range: assert property (@(posedge hclk)
        disable iff (!hresetn) rx_message_count <= LVL_MAX)
        else $error("message count above eight");
    a_slot_crc_follow: assert property (@(posedge hclk)
        disable iff (!hresetn)
        commit |=> slot_crc_error == $past(rx_crc_bad))
        else $error("slot crc flag not refreshed");
    a_user_hold: assert property (@(posedge hclk)
        disable iff (!hresetn)
        s_clean_commit |=> user == $past(rx_user) ##2
        (!fctrl[FC_PROT] || rx_user2_pin == user[2]))
        else $error("user bits not taken");
    a_link_hold: assert property (@(posedge hclk)
        disable iff (!hresetn)
        commit && rx_crc_bad |=> $stable(link))
        else $error("link taken from bad message");
    a_valid_window: assert property (@(posedge hclk)
        disable iff (!hresetn) commit |=> !status_valid)
        else $error("status valid during update");
    a_user0_rise: assert property (@(posedge hclk)
        disable iff (!hresetn)
        s_clean_commit ##0 (rx_user[0] && !user[0])
        |=> reason[RS_USER0])
        else $error("user0 rise lost");
    a_ovf_set: assert property (@(posedge hclk)
        disable iff (!hresetn) commit && full |=> reason[RS_OVF])
        else $error("overflow not flagged");
    a_read_clear: assert property (@(posedge hclk)
        disable iff (!hresetn)
        s_reason_read |-> (reason & ~$past(sets)) == 7'h00)
        else $error("reason not cleared on read");
    a_irq_follow: assert property (@(posedge hclk)
        disable iff (!hresetn)
        |(reason & en_ctrl[6:0]) |=> irq)
        else $error("interrupt not raised");
    a_busy_sync: assert property (@(posedge hclk)
        disable iff (!hresetn)
        st == RXM_IDLE && wr_sync
        |=> ##1 fifo_transfer_busy ##[1:4] !fifo_transfer_busy)
        else $error("resync busy too long");
endmodule

/* rtl/rxmsg_pkg.sv */
package rxmsg_pkg;
    // ========================================================
    // Register map: word indices, byte address is index * 4.
    localparam int          ADDR_W       = 10;
    localparam logic [7:0]  IDX_DATA     = 8'ha6;
    localparam logic [7:0]  IDX_FCTRL    = 8'ha9;
    localparam logic [7:0]  IDX_STATUS   = 8'hab;
    localparam logic [7:0]  IDX_IRQ_EN   = 8'had;
    localparam logic [7:0]  IDX_REASON   = 8'haf;
    // ========================================================
    // Enable and control register fields and reset value.
    localparam int          EN_TMO_LSB   = 11;
    localparam int          EN_THR_LSB   = 8;
    localparam logic [15:0] EN_RESET     = 16'h0500;
    localparam logic [15:0] EN_RW_MASK   = 16'h1f7f;
    // ========================================================
    // Reason bit positions.
    localparam int          RS_USER0     = 0;
    localparam int          RS_PAGE_LSB  = 1;
    localparam int          RS_LINK      = 3;
    localparam int          RS_OVF       = 4;
    localparam int          RS_THR       = 5;
    localparam int          RS_TMO       = 6;
    // ========================================================
    // Control register bits.
    localparam int          FC_FAST      = 2;
    localparam int          FC_PROT      = 3;
    // ========================================================
    // Status register fields.
    localparam int          ST_VALID     = 15;
    localparam int          ST_LINK_LSB  = 13;
    localparam int          ST_PAGE_LSB  = 11;
    localparam int          ST_USER_LSB  = 8;
    localparam int          ST_HEAD_CRC  = 7;
    localparam int          ST_SLOT_CRC  = 6;
    localparam int          ST_LVL_LSB   = 2;
    localparam int          ST_BUSY      = 1;
    localparam int          ST_SYNC_DONE = 0;
    // ========================================================
    // Timing: frame period and FIFO access latencies.
    localparam int          CLK_MHZ      = 100;
    localparam int          FRAME_US     = 125;
    localparam int          FRAME_CYC    = FRAME_US * CLK_MHZ;
    localparam logic [2:0]  RD_CYC_SLOW  = 3'h4;
    localparam logic [2:0]  RD_CYC_FAST  = 3'h3;
    localparam logic [2:0]  SYNC_CYC_SLOW = 3'h5;
    localparam logic [2:0]  SYNC_CYC_FAST = 3'h4;
    localparam logic [3:0]  LVL_MAX      = 4'h8;
    // ========================================================
    // FIFO transfer engine states.
    typedef enum logic [1:0] {RXM_IDLE, RXM_READ, RXM_SYNC} rxmsg_st_t;
endpackage

/* bench/rxmsg_peer.sv */
`timescale 1ns/1ps
// ============================================================
// Peer model: sends one slot of eight words, then the header.
module rxmsg_peer (
    input  wire logic        hclk,
    output logic             rx_word_valid,
    output logic      [31:0] rx_word,
    output logic             rx_msg_done,
    output logic             rx_crc_bad,
    output logic      [6:0]  rx_hdr
);
    // Idle lines carry the inverse of the last value, so stale
    // data can never pass for fresh data.
    initial begin
        rx_word_valid = 1'b0;
        rx_msg_done   = 1'b0;
        rx_word       = 32'h0;
        rx_crc_bad    = 1'b0;
        rx_hdr        = 7'h0;
    end
    // Header h is {user, page, link}.
    task automatic send(input logic [6:0] h, input logic bad,
                        input logic [31:0] w0);
        int i;
        for (i = 0; i < 8; i++) begin
            @(posedge hclk);
            rx_word_valid <= 1'b1;
            rx_word       <= w0 + 32'(i);
        end
        @(posedge hclk);
        rx_word_valid <= 1'b0;
        rx_word       <= ~(w0 + 32'h7);
        rx_msg_done   <= 1'b1;
        rx_crc_bad    <= bad;
        rx_hdr        <= h;
        @(posedge hclk);
        rx_msg_done   <= 1'b0;
        rx_crc_bad    <= ~bad;
        rx_hdr        <= ~h;
    endtask
endmodule

/* bench/tb_rx_message_status_irq.sv */
`timescale 1ns/1ps
// ============================================================
// Bench: registers over AHB-Lite, messages from the peer model.
module tb_rx_message_status_irq;
    import rxmsg_pkg::*;
    logic              hclk    = 1'b0;
    logic              hresetn = 1'b0;
    logic              hsel    = 1'b0;
    logic [ADDR_W-1:0] haddr   = '0;
    logic [1:0]        htrans  = 2'h0;
    logic              hwrite  = 1'b0;
    logic [31:0]       hwdata  = 32'h0;
    logic [31:0]       hrdata, s, d;
    logic              hreadyout, hresp, irq, rx_word_valid;
    logic              rx_msg_done, rx_crc_bad, pin2, ims, oms;
    logic [31:0]       rx_word;
    logic [6:0]        rx_hdr;
    int                fail_count = 0;
    int                n_checks   = 0;
    int                i, n;
    always #5 hclk = ~hclk;
    rxmsg_irq #(.FRAME_CYCLES(20)) rxmsg_irq_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
        .rx_word_valid(rx_word_valid), .rx_word(rx_word),
        .rx_msg_done(rx_msg_done), .rx_crc_bad(rx_crc_bad),
        .rx_user(rx_hdr[6:4]), .rx_page(rx_hdr[3:2]),
        .rx_link(rx_hdr[1:0]), .rx_user2_pin(pin2),
        .input_memory_switch(ims), .output_memory_switch(oms));
    rxmsg_peer rxmsg_peer_inst (
        .hclk(hclk), .rx_word_valid(rx_word_valid), .rx_word(rx_word),
        .rx_msg_done(rx_msg_done), .rx_crc_bad(rx_crc_bad),
        .rx_hdr(rx_hdr));
    // Compare one value and count it.
    task automatic chk(input logic [31:0] got, exp, input string m);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask
    // One single transfer; waits on hready in both phases.
    task automatic ahb(input logic w, input logic [7:0] idx,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {idx, 2'h0};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    // Poll status until valid and idle, then read once more, since
    // the head flag may settle together with busy.
    task automatic stat();
        for (i = 0; i < 40; i++) begin
            ahb(1'b0, IDX_STATUS, 32'h0, s);
            if (s[ST_VALID] === 1'b1 && s[ST_BUSY] === 1'b0) break;
        end
        ahb(1'b0, IDX_STATUS, 32'h0, s);
    endtask
    // Count cycles until irq rises, bounded.
    task automatic wirq();
        for (n = 0; n < 200 && irq !== 1'b1; n++) @(posedge hclk);
    endtask
    task automatic t_reset();
        ahb(1'b0, IDX_IRQ_EN, 32'h0, d);
        chk(d & 32'hffff, 32'h0500, "enable reset");
        ahb(1'b0, IDX_REASON, 32'h0, d);
        chk(d & 32'h3f, 32'h0, "reason reset");
        ahb(1'b0, 8'h00, 32'h0, d);
        chk(d, 32'h0, "unmapped read");
        chk({31'h0, hresp}, 32'h0, "okay response");
    endtask
    // Header changes, bad slot's header ignored, falling user0 not flagged.
    task automatic t_change();
        ahb(1'b1, IDX_IRQ_EN, 32'h050f, d);
        rxmsg_peer_inst.send(7'h1d, 1'b0, 32'h1000);
        wirq();
        chk({31'h0, irq}, 32'h1, "irq on change");
        ahb(1'b0, IDX_REASON, 32'h0, d);
        chk(d & 32'h3f, 32'h0f, "change flags");
        repeat (3) @(posedge hclk);
        chk({31'h0, irq}, 32'h0, "irq after clear");
        rxmsg_peer_inst.send(7'h02, 1'b1, 32'h2000);
        stat();
        chk(s & 32'h7f7c, 32'h3948, "bad slot");
        rxmsg_peer_inst.send(7'h0d, 1'b0, 32'h3000);
        stat();
        chk(s & 32'h7f7c, 32'h380c, "clean slot");
        chk({29'h0, pin2, ims, oms}, 32'h0, "pins off");
        ahb(1'b1, IDX_STATUS, 32'h0001, d);
        stat();
        chk(s & 32'h83, 32'h01, "slow sync");
        ahb(1'b0, IDX_REASON, 32'h0, d);
        chk(d & 32'h3f, 32'h0, "no falling flag");
    endtask
    // Protection link selected: pins follow the clean header.
    task automatic t_prot();
        ahb(1'b1, IDX_FCTRL, 32'h000c, d);
        rxmsg_peer_inst.send(7'h49, 1'b0, 32'h4000);
        stat();
        chk(s & 32'h7f7c, 32'h3410, "prot status");
        chk({29'h0, pin2, ims, oms}, 32'h6, "pins");
        ahb(1'b0, IDX_REASON, 32'h0, d);
        chk(d & 32'h3f, 32'h02, "page0 flag");
    endtask
    // Fill to eight at threshold code 111, then overflow.
    task automatic t_fill();
        ahb(1'b1, IDX_IRQ_EN, 32'h0730, d);
        for (i = 0; i < 4; i++)
            rxmsg_peer_inst.send(7'h49, 1'b0, 32'h5000);
        ahb(1'b0, IDX_REASON, 32'h0, d);
        chk(d & 32'h3f, 32'h20, "threshold");
        rxmsg_peer_inst.send(7'h49, 1'b0, 32'h6000);
        wirq();
        chk({31'h0, irq}, 32'h1, "irq overflow");
        ahb(1'b0, IDX_REASON, 32'h0, d);
        chk(d & 32'h3f, 32'h10, "overflow");
        stat();
        chk(s & 32'h7f7c, 32'h3420, "level max");
    endtask
    // Resync, read one message, then wait for the timeout.
    task automatic t_read();
        ahb(1'b1, IDX_IRQ_EN, 32'h0040, d);
        ahb(1'b1, IDX_STATUS, 32'h0001, d);
        stat();
        chk(s & 32'h81, 32'h01, "sync done");
        for (int k = 0; k < 8; k++) begin
            stat();
            ahb(1'b0, IDX_DATA, 32'h0, d);
            chk(d, 32'h1000 + 32'(k), "fifo word");
        end
        ahb(1'b0, IDX_REASON, 32'h0, d);
        wirq();
        chk({31'h0, n >= 10 && n <= 45}, 32'h1, "timeout");
        ahb(1'b0, IDX_REASON, 32'h0, d);
        chk(d & 32'h40, 32'h40, "timeout flag");
        stat();
        chk(s & 32'h7ffc, 32'h349c, "head crc");
    endtask
    task automatic summarize();
        $display("checks %0d failures %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_change();
        t_prot();
        t_fill();
        t_read();
        summarize();
    end
    // Watchdog: the whole run needs a few hundred cycles.
    initial begin
        #200000;
        fail_count++;
        summarize();
    end
endmodule
